// [dv/gpz_pin_model.sv]
// board side of one port: drive, board source, pull-up, else the inverse of the output value
`timescale 1ns/1ps
`default_nettype none
module gpz_pin_model #(
  parameter int W = 8
) (
  input wire logic [W-1:0] pin_o,
  input wire logic [W-1:0] pin_oe,
  input wire logic [W-1:0] pull_on,
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_en,
  output logic [W-1:0] pin_i
);
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (pin_oe[i]) pin_i[i] = pin_o[i];
      else if (ext_en[i]) pin_i[i] = ext_val[i];
      else if (pull_on[i]) pin_i[i] = 1'b1;
      else pin_i[i] = ~pin_o[i];
    end
  end
endmodule : gpz_pin_model
`default_nettype wire

// [dv/gpz_ports_asserts.sv]
// concurrent checks on the port block's bus and pins
`timescale 1ns/1ps
`default_nettype none
module gpz_ports_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic [6:0] port0_alt_drive_en,
  input wire logic [6:0] port0_alt_data,
  input wire logic [6:0] port0_pin_o,
  input wire logic [7:0] port1_pin_oe,
  input wire logic [7:0] port1_pullup_on,
  input wire logic [7:0] analog_input_channels,
  input wire logic [3:0] port4_pin_i,
  input wire logic [3:0] port4_level
);
  logic [1:0] up_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_after_setup: assert property (psel && !penable |=> pready && penable)
    else $error("no answer after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  chk_pullup_input_only: assert property ((port1_pullup_on & port1_pin_oe) == 8'h0)
    else $error("pull-up on a driven pin");
  chk_reset_all_input: assert property ($rose(presetn) |-> ##1 port1_pin_oe == 8'h0)
    else $error("pin driven after reset");
  chk_analog_reset: assert property ($rose(presetn) |=> analog_input_channels == 8'hff)
    else $error("port 2 not analog after reset");
  chk_dir_by_write: assert property ($changed(port1_pin_oe) |->
    $past(psel && penable && pready && pwrite, 2))
    else $error("drive changed without a write");
  chk_level_sync: assert property (up_q == 2'h3 |-> port4_level == $past(port4_pin_i, 2))
    else $error("pin level not two edges behind");
  chk_alt_override: assert property (|port0_alt_drive_en |=>
    ((port0_pin_o ^ $past(port0_alt_data)) & $past(port0_alt_drive_en)) == 7'h0)
    else $error("peripheral value not on pin");
endmodule : gpz_ports_asserts
`default_nettype wire

// [dv/gpz_ports_test.sv]
// self-checking bench for the port block
`timescale 1ns/1ps
`default_nettype none
module gpz_ports_test;
  import gpz_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [6:0] port0_pin_i, port0_pin_o, port0_pin_oe, port0_pullup_on, port0_level;
  logic [6:0] port0_alt_drive_en, port0_alt_data;
  logic [7:0] port1_pin_i, port1_pin_o, port1_pin_oe, port1_pullup_on, port1_level;
  logic [7:0] port2_pin_i, port2_pin_o, port2_pin_oe, port2_level, analog_input_channels;
  logic [7:0] p1_ext, p1_ext_en, p2_ext, p2_ext_en;
  logic [2:0] converter_channel_select;
  logic [3:0] port3_pin_i, port3_pin_o, port3_pin_oe, port3_pullup_on, port3_level;
  logic [3:0] port3_alt_drive_en, port3_alt_data;
  logic [3:0] port4_pin_i, port4_pin_o, port4_pin_oe, port4_pullup_on, port4_level;
  logic [3:0] port5_pin_i, port5_pin_o, port5_pin_oe, port5_pullup_on, port5_level;
  logic [31:0] rst_rd [6] = '{32'h55, 32'h3c, 32'h0, 32'h9, 32'h6, 32'ha};
  int num_errors = 0;
  int total_checks = 0;
  gpz_ports i_dut (.*);
  gpz_pin_model #(.W(8)) i_p1 (.pin_o(port1_pin_o), .pin_oe(port1_pin_oe),
    .pull_on(port1_pullup_on), .ext_val(p1_ext), .ext_en(p1_ext_en), .pin_i(port1_pin_i));
  gpz_pin_model #(.W(8)) i_p2 (.pin_o(port2_pin_o), .pin_oe(port2_pin_oe),
    .pull_on(8'h0), .ext_val(p2_ext), .ext_en(p2_ext_en), .pin_i(port2_pin_i));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction : ad
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [31:0] exp, input logic ee);
    logic [31:0] r;
    logic e;
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t no ready from slave", $time);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (!w) cmp(r, exp);
    cmp({31'h0, e}, {31'h0, ee});
  endtask : xfer
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    xfer(1'b1, ad(i), d, 32'h0, 1'b0);
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [31:0] exp);
    xfer(1'b0, ad(i), 32'h0, exp, 1'b0);
  endtask : rd
  task automatic settle;
    repeat (3) @(posedge pclk);
  endtask : settle
  task automatic t_reset;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    cmp(32'(analog_input_channels), 32'hff);
    cmp(32'(port1_pin_oe | port2_pin_oe), 32'h0);
    cmp(32'({port0_pin_oe, port3_pin_oe, port4_pin_oe, port5_pin_oe}), 32'h0);
    cmp(32'({port0_pullup_on, port1_pullup_on, port3_pullup_on, port5_pullup_on}), 32'h0);
    for (int i = 0; i < NUM_PORTS; i++) begin
      rd(IDX_DIR_BASE + 8'(i), 32'hff);
      rd(IDX_LATCH_BASE + 8'(i), rst_rd[i]);
      if (i != 2) rd(IDX_PU_BASE + 8'(i), 32'h0);
    end
    rd(IDX_ANALOG_DIGITAL_PIN_CONFIG, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_port1;
    wr(IDX_LATCH_BASE + 8'h1, 32'ha5);
    wr(IDX_DIR_BASE + 8'h1, 32'hf0);
    settle;
    cmp(32'(port1_pin_oe), 32'h0f);
    cmp(32'(port1_pin_o & 8'h0f), 32'h05);
    rd(IDX_LATCH_BASE + 8'h1, 32'h35);
    p1_ext_en <= 8'h0;
    wr(IDX_PU_BASE + 8'h1, 32'hff);
    settle;
    cmp(32'(port1_pullup_on), 32'hf0);
    rd(IDX_LATCH_BASE + 8'h1, 32'hf5);
    $display("port 1 test done");
  endtask : t_port1
  task automatic t_bits;
    wr(IDX_BITWR, 32'h302);
    rd(IDX_DIR_BASE + 8'h3, 32'hfb);
    wr(IDX_BITWR, 32'h130a);
    wr(IDX_PU_BASE + 8'h3, 32'hf);
    rd(IDX_BITWR, 32'h0);
    settle;
    cmp(32'(port3_pin_oe), 32'h4);
    cmp(32'(port3_pin_o & 4'h4), 32'h4);
    cmp(32'(port3_pullup_on), 32'hb);
    port3_alt_drive_en <= 4'h4;
    port0_alt_drive_en <= 7'h05;
    port0_alt_data <= 7'h04;
    settle;
    cmp(32'(port3_pin_o & 4'h4), 32'h0);
    cmp(32'(port0_pin_o & 7'h05), 32'h4);
    port3_alt_drive_en <= 4'h0;
    port0_alt_drive_en <= 7'h0;
    $display("bit write test done");
  endtask : t_bits
  task automatic t_port2;
    p2_ext <= 8'h02;
    wr(IDX_LATCH_BASE + 8'h2, 32'h01);
    wr(IDX_ANALOG_DIGITAL_PIN_CONFIG, 32'h03);
    wr(IDX_DIR_BASE + 8'h2, 32'hfe);
    wr(IDX_ADS, 32'h2);
    settle;
    cmp(32'(analog_input_channels), 32'hfc);
    cmp(32'(port2_pin_oe), 32'h01);
    cmp(32'(port2_pin_o & 8'h01), 32'h01);
    cmp(32'(converter_channel_select), 32'h2);
    rd(IDX_LATCH_BASE + 8'h2, 32'h03);
    rd(IDX_STATUS, 32'h0);
    wr(IDX_ADS, 32'h0);
    wr(IDX_DIR_BASE + 8'h2, 32'h7e);
    settle;
    rd(IDX_STATUS, 32'h81);
    cmp(32'(port2_pin_oe), 32'h01);
    xfer(1'b0, ad(IDX_PU_BASE + 8'h2), 32'h0, 32'h0, 1'b1);
    xfer(1'b1, ad(IDX_STATUS), 32'hff, 32'h0, 1'b1);
    $display("port 2 test done");
  endtask : t_port2
  task automatic t_widths;
    port4_pin_i <= 4'h3;
    settle;
    rd(IDX_LATCH_BASE + 8'h4, 32'h3);
    wr(IDX_DIR_BASE, 32'h0);
    rd(IDX_DIR_BASE, 32'h80);
    wr(IDX_DIR_BASE + 8'h4, 32'h0);
    rd(IDX_DIR_BASE + 8'h4, 32'hf0);
    wr(IDX_LATCH_BASE + 8'h4, 32'h1a);
    rd(IDX_LATCH_BASE + 8'h4, 32'h0a);
    wr(IDX_PU_BASE + 8'h5, 32'h5);
    settle;
    cmp(32'(port0_pin_oe), 32'h7f);
    cmp(32'(port4_pin_oe), 32'hf);
    cmp(32'(port4_pin_o), 32'ha);
    cmp(32'(port0_pin_o), 32'h0);
    cmp(32'(port5_pullup_on), 32'h5);
    cmp(32'({port3_level, port5_level}), 32'h9a);
    port4_pin_i <= 4'h6;
    p1_ext_en <= 8'hff;
    $display("width test done");
  endtask : t_widths
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #(25 * 4000);
    num_errors++;
    tally_and_finish;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {port0_pin_i, port3_pin_i, port4_pin_i, port5_pin_i} = {7'h55, 4'h9, 4'h6, 4'ha};
    {port0_alt_drive_en, port0_alt_data, port3_alt_drive_en, port3_alt_data} = '0;
    {p1_ext, p1_ext_en, p2_ext, p2_ext_en} = {8'h3c, 8'hff, 8'h0, 8'hfe};
    t_reset;
    t_port1;
    t_bits;
    t_port2;
    t_widths;
    t_reset;
    tally_and_finish;
  end
endmodule : gpz_ports_test
bind gpz_ports gpz_ports_asserts i_chk (.*);
`default_nettype wire

// [hdl/gpz_pkg.sv]
// constants shared by the port block: register map, fields, reset values
package gpz_pkg;
  localparam int NUM_PORTS = 6;
  localparam int P0_W = 7;
  localparam int P1_W = 8;
  localparam int P2_W = 8;
  localparam int P3_W = 4;
  localparam int P4_W = 4;
  localparam int P5_W = 4;
  localparam int PINS_PUSH_PULL = 50;
  localparam int PINS_OUTPUT_ONLY = 1;
  localparam int PINS_OPEN_DRAIN = 4;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  localparam logic [7:0] IDX_LATCH_BASE = 8'h00;
  localparam logic [7:0] IDX_DIR_BASE = 8'h20;
  localparam logic [7:0] IDX_PU_BASE = 8'h30;
  localparam logic [7:0] IDX_ANALOG_DIGITAL_PIN_CONFIG = 8'h40;
  localparam logic [7:0] IDX_ADS = 8'h41;
  localparam logic [7:0] IDX_BITWR = 8'h42;
  localparam logic [7:0] IDX_STATUS = 8'h43;
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] PU_RST = 8'h00;
  localparam logic [7:0] ANALOG_DIGITAL_PIN_CONFIG_RST = 8'h00;
  localparam logic [2:0] ADS_RST = 3'h0;
  localparam int BW_BIT_LSB = 0;
  localparam int BW_BIT_MSB = 2;
  localparam int BW_VAL_POS = 3;
  localparam int BW_PORT_LSB = 8;
  localparam int BW_PORT_MSB = 10;
  localparam int BW_TGT_POS = 12;
  localparam int ADS_MSB = 2;
endpackage : gpz_pkg

// [hdl/gpz_port_slice.sv]
// one port: latch, direction, pull-up, pin synchroniser and pin drivers
`timescale 1ns/1ps
`default_nettype none
module gpz_port_slice
  import gpz_pkg::*;
#(
  parameter int W = 8,
  parameter bit HAS_PU = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] pin_i,
  input wire logic wr_latch,
  input wire logic wr_dir,
  input wire logic wr_pu,
  input wire logic [7:0] wdata,
  input wire logic bit_wr_dir,
  input wire logic bit_wr_latch,
  input wire logic [2:0] bit_sel,
  input wire logic bit_val,
  input wire logic [W-1:0] alt_en,
  input wire logic [W-1:0] alt_o,
  input wire logic [W-1:0] analog,
  output logic [W-1:0] latch_q,
  output logic [W-1:0] dir_q,
  output logic [W-1:0] pu_q,
  output logic [W-1:0] rd_port,
  output logic [W-1:0] level_q,
  output logic [W-1:0] pin_o_q,
  output logic [W-1:0] pin_oe_q,
  output logic [W-1:0] pullup_on_q
);
  logic [W-1:0] sync1_q;

  // output latch, byte or single bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= LATCH_RST[W-1:0];
    end else if (wr_latch) begin
      latch_q <= wdata[W-1:0];
    end else if (bit_wr_latch) begin
      for (int i = 0; i < W; i++) begin
        if (bit_sel == 3'(i)) latch_q[i] <= bit_val;
      end
    end
  end

  // direction: 1 input, 0 output; reset all inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= DIR_RST[W-1:0]; // [R4] [R18]
    end else if (wr_dir) begin
      dir_q <= wdata[W-1:0]; // [R2] [R18]
    end else if (bit_wr_dir) begin
      for (int i = 0; i < W; i++) begin
        if (bit_sel == 3'(i)) dir_q[i] <= bit_val; // [R2] [R18]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pu_q <= PU_RST[W-1:0];
    end else if (wr_pu && HAS_PU) begin
      pu_q <= wdata[W-1:0];
    end
  end

  // two-flop pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      level_q <= '0;
    end else begin
      sync1_q <= pin_i;
      level_q <= sync1_q;
    end
  end

  // registered pin drivers; analog pins never drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_o_q <= '0;
      pin_oe_q <= '0;
      pullup_on_q <= '0;
    end else begin
      pin_o_q <= (alt_en & alt_o) | (~alt_en & latch_q); // [R1] [R15] [R16]
      pin_oe_q <= ~dir_q & ~analog; // [R2] [R12] [R17]
      pullup_on_q <= HAS_PU ? (pu_q & dir_q & ~analog) : '0; // [R3]
    end
  end

  // input pins show the pin, output pins the latch; analog pins read zero
  assign rd_port = ((dir_q & level_q) | (~dir_q & latch_q)) & ~analog; // [R19]
endmodule : gpz_port_slice
`default_nettype wire

// [hdl/gpz_ports.sv]
// general-purpose ports 0 to 5 with an APB register slave
//
// Summary of operation
// R1: port 0 has seven pins, each with an output latch bit.
// R2: every pin has its own direction bit, input or output.
// R3: ports 0,1,3,4,5 have per-pin pull-ups active only in input mode.
// R4: reset puts all pins of ports 0,1,3,4,5 in input mode.
// R5: port 1 has eight pins with latch, direction and pull-up.
// R6: port 2 has eight pins with latch and direction, shared with analog, no pull-up.
// R7: ports 3, 4 and 5 are four-pin ports with latch, direction, pull-up.
// R8: software clears serial B mode and clock select before plain use of its pins.
// R9: software clears serial A mode and clock select before plain use of its pins.
// R10: port 2 digital input needs digital config and input direction.
// R11: port 2 digital output needs digital config and output direction.
// R12: analog input pins convert when selected; other mixed combinations are prohibited.
// R13: reset sets all port 2 pins to analog input.
// R14: software assigns port 2 digital pins from the lowest pin upward.
// R15: port 0 pins can be taken by timer and serial functions.
// R16: port 3 pins can be taken by interrupt and timer functions.
// R17: the full port system has 50 push-pull, 1 output-only, 4 open-drain pins.
// R18: direction registers reset to all ones, writable by byte or bit.
// R19: port read gives pin level for inputs, latch value for outputs.
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module gpz_ports
  import gpz_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [P0_W-1:0] port0_pin_i,
  output logic [P0_W-1:0] port0_pin_o,
  output logic [P0_W-1:0] port0_pin_oe,
  output logic [P0_W-1:0] port0_pullup_on,
  output logic [P0_W-1:0] port0_level,
  input wire logic [P0_W-1:0] port0_alt_drive_en,
  input wire logic [P0_W-1:0] port0_alt_data,
  input wire logic [P1_W-1:0] port1_pin_i,
  output logic [P1_W-1:0] port1_pin_o,
  output logic [P1_W-1:0] port1_pin_oe,
  output logic [P1_W-1:0] port1_pullup_on,
  output logic [P1_W-1:0] port1_level,
  input wire logic [P2_W-1:0] port2_pin_i,
  output logic [P2_W-1:0] port2_pin_o,
  output logic [P2_W-1:0] port2_pin_oe,
  output logic [P2_W-1:0] port2_level,
  output logic [P2_W-1:0] analog_input_channels,
  output logic [ADS_MSB:0] converter_channel_select,
  input wire logic [P3_W-1:0] port3_pin_i,
  output logic [P3_W-1:0] port3_pin_o,
  output logic [P3_W-1:0] port3_pin_oe,
  output logic [P3_W-1:0] port3_pullup_on,
  output logic [P3_W-1:0] port3_level,
  input wire logic [P3_W-1:0] port3_alt_drive_en,
  input wire logic [P3_W-1:0] port3_alt_data,
  input wire logic [P4_W-1:0] port4_pin_i,
  output logic [P4_W-1:0] port4_pin_o,
  output logic [P4_W-1:0] port4_pin_oe,
  output logic [P4_W-1:0] port4_pullup_on,
  output logic [P4_W-1:0] port4_level,
  input wire logic [P5_W-1:0] port5_pin_i,
  output logic [P5_W-1:0] port5_pin_o,
  output logic [P5_W-1:0] port5_pin_oe,
  output logic [P5_W-1:0] port5_pullup_on,
  output logic [P5_W-1:0] port5_level
);
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [7:0] idx;
  logic acc;
  logic wr;
  logic [NUM_PORTS-1:0] wr_latch;
  logic [NUM_PORTS-1:0] wr_dir;
  logic [NUM_PORTS-1:0] wr_pu;
  logic [NUM_PORTS-1:0] bw_dir;
  logic [NUM_PORTS-1:0] bw_latch;
  logic [7:0] latch_rd [NUM_PORTS];
  logic [7:0] dir_rd [NUM_PORTS];
  logic [7:0] pu_rd [NUM_PORTS];
  logic [7:0] port_rd [NUM_PORTS];
  logic [P0_W-1:0] l0, d0, u0, r0;
  logic [P1_W-1:0] l1, d1, u1, r1;
  logic [P2_W-1:0] l2, d2, u2, r2;
  logic [P3_W-1:0] l3, d3, u3, r3;
  logic [P4_W-1:0] l4, d4, u4, r4;
  logic [P5_W-1:0] l5, d5, u5, r5;
  logic [7:0] analog_digital_pin_config_q;
  logic [ADS_MSB:0] ads_q;
  logic [7:0] prohibited;
  logic [P2_W-1:0] analog2;
  logic [P2_W-1:0] chan_q;
  logic [31:0] rd_mux;
  logic mapped;
  logic [2:0] bw_port;

  assign idx = paddr[IDX_MSB:IDX_LSB];
  assign acc = psel & penable & pready_q;
  assign wr = acc & pwrite;
  assign bw_port = pwdata[BW_PORT_MSB:BW_PORT_LSB];

  // write strobes per port, whole byte or single bit
  always_comb begin
    for (int n = 0; n < NUM_PORTS; n++) begin
      wr_latch[n] = wr && (idx == IDX_LATCH_BASE + 8'(n));
      wr_dir[n] = wr && (idx == IDX_DIR_BASE + 8'(n)); // [R18]
      wr_pu[n] = wr && (idx == IDX_PU_BASE + 8'(n)) && (n != 2); // [R6]
      bw_dir[n] = wr && (idx == IDX_BITWR) && (bw_port == 3'(n)) && !pwdata[BW_TGT_POS]; // [R18]
      bw_latch[n] = wr && (idx == IDX_BITWR) && (bw_port == 3'(n)) && pwdata[BW_TGT_POS];
    end
  end

  // analog/digital config (1 = digital) and converter channel select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_digital_pin_config_q <= ANALOG_DIGITAL_PIN_CONFIG_RST; // [R13]
    end else if (wr && idx == IDX_ANALOG_DIGITAL_PIN_CONFIG) begin
      analog_digital_pin_config_q <= pwdata[7:0]; // [R10] [R11] [R14]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ads_q <= ADS_RST;
    end else if (wr && idx == IDX_ADS) begin
      ads_q <= pwdata[ADS_MSB:0];
    end
  end

  assign analog2 = ~analog_digital_pin_config_q; // [R12] [R13]

  // prohibited port 2 settings, shown live in the status register
  always_comb begin
    for (int i = 0; i < P2_W; i++) begin
      prohibited[i] = (analog2[i] & ~d2[i]) | (analog_digital_pin_config_q[i] & (ads_q == 3'(i))); // [R12]
    end
  end

  // pin routing to the converter: analog and input only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_q <= '0;
    end else begin
      chan_q <= analog2 & d2; // [R12]
    end
  end

  assign analog_input_channels = chan_q;
  assign converter_channel_select = ads_q;

  gpz_port_slice #(.W(P0_W), .HAS_PU(1'b1)) u_port0 ( // [R1] [R15]
    .pclk(pclk), .presetn(presetn), .pin_i(port0_pin_i),
    .wr_latch(wr_latch[0]), .wr_dir(wr_dir[0]), .wr_pu(wr_pu[0]), .wdata(pwdata[7:0]),
    .bit_wr_dir(bw_dir[0]), .bit_wr_latch(bw_latch[0]),
    .bit_sel(pwdata[BW_BIT_MSB:BW_BIT_LSB]), .bit_val(pwdata[BW_VAL_POS]),
    .alt_en(port0_alt_drive_en), .alt_o(port0_alt_data), .analog('0),
    .latch_q(l0), .dir_q(d0), .pu_q(u0), .rd_port(r0), .level_q(port0_level),
    .pin_o_q(port0_pin_o), .pin_oe_q(port0_pin_oe), .pullup_on_q(port0_pullup_on)
  );

  gpz_port_slice #(.W(P1_W), .HAS_PU(1'b1)) u_port1 ( // [R5]
    .pclk(pclk), .presetn(presetn), .pin_i(port1_pin_i),
    .wr_latch(wr_latch[1]), .wr_dir(wr_dir[1]), .wr_pu(wr_pu[1]), .wdata(pwdata[7:0]),
    .bit_wr_dir(bw_dir[1]), .bit_wr_latch(bw_latch[1]),
    .bit_sel(pwdata[BW_BIT_MSB:BW_BIT_LSB]), .bit_val(pwdata[BW_VAL_POS]),
    .alt_en('0), .alt_o('0), .analog('0),
    .latch_q(l1), .dir_q(d1), .pu_q(u1), .rd_port(r1), .level_q(port1_level),
    .pin_o_q(port1_pin_o), .pin_oe_q(port1_pin_oe), .pullup_on_q(port1_pullup_on)
  );

  gpz_port_slice #(.W(P2_W), .HAS_PU(1'b0)) u_port2 ( // [R6]
    .pclk(pclk), .presetn(presetn), .pin_i(port2_pin_i),
    .wr_latch(wr_latch[2]), .wr_dir(wr_dir[2]), .wr_pu(1'b0), .wdata(pwdata[7:0]),
    .bit_wr_dir(bw_dir[2]), .bit_wr_latch(bw_latch[2]),
    .bit_sel(pwdata[BW_BIT_MSB:BW_BIT_LSB]), .bit_val(pwdata[BW_VAL_POS]),
    .alt_en('0), .alt_o('0), .analog(analog2),
    .latch_q(l2), .dir_q(d2), .pu_q(u2), .rd_port(r2), .level_q(port2_level),
    .pin_o_q(port2_pin_o), .pin_oe_q(port2_pin_oe), .pullup_on_q()
  );

  gpz_port_slice #(.W(P3_W), .HAS_PU(1'b1)) u_port3 ( // [R7] [R16]
    .pclk(pclk), .presetn(presetn), .pin_i(port3_pin_i),
    .wr_latch(wr_latch[3]), .wr_dir(wr_dir[3]), .wr_pu(wr_pu[3]), .wdata(pwdata[7:0]),
    .bit_wr_dir(bw_dir[3]), .bit_wr_latch(bw_latch[3]),
    .bit_sel(pwdata[BW_BIT_MSB:BW_BIT_LSB]), .bit_val(pwdata[BW_VAL_POS]),
    .alt_en(port3_alt_drive_en), .alt_o(port3_alt_data), .analog('0),
    .latch_q(l3), .dir_q(d3), .pu_q(u3), .rd_port(r3), .level_q(port3_level),
    .pin_o_q(port3_pin_o), .pin_oe_q(port3_pin_oe), .pullup_on_q(port3_pullup_on)
  );

  gpz_port_slice #(.W(P4_W), .HAS_PU(1'b1)) u_port4 ( // [R7]
    .pclk(pclk), .presetn(presetn), .pin_i(port4_pin_i),
    .wr_latch(wr_latch[4]), .wr_dir(wr_dir[4]), .wr_pu(wr_pu[4]), .wdata(pwdata[7:0]),
    .bit_wr_dir(bw_dir[4]), .bit_wr_latch(bw_latch[4]),
    .bit_sel(pwdata[BW_BIT_MSB:BW_BIT_LSB]), .bit_val(pwdata[BW_VAL_POS]),
    .alt_en('0), .alt_o('0), .analog('0),
    .latch_q(l4), .dir_q(d4), .pu_q(u4), .rd_port(r4), .level_q(port4_level),
    .pin_o_q(port4_pin_o), .pin_oe_q(port4_pin_oe), .pullup_on_q(port4_pullup_on)
  );

  gpz_port_slice #(.W(P5_W), .HAS_PU(1'b1)) u_port5 ( // [R7]
    .pclk(pclk), .presetn(presetn), .pin_i(port5_pin_i),
    .wr_latch(wr_latch[5]), .wr_dir(wr_dir[5]), .wr_pu(wr_pu[5]), .wdata(pwdata[7:0]),
    .bit_wr_dir(bw_dir[5]), .bit_wr_latch(bw_latch[5]),
    .bit_sel(pwdata[BW_BIT_MSB:BW_BIT_LSB]), .bit_val(pwdata[BW_VAL_POS]),
    .alt_en('0), .alt_o('0), .analog('0),
    .latch_q(l5), .dir_q(d5), .pu_q(u5), .rd_port(r5), .level_q(port5_level),
    .pin_o_q(port5_pin_o), .pin_oe_q(port5_pin_oe), .pullup_on_q(port5_pullup_on)
  );

  // byte views; unused direction bits read as one, others as zero
  assign latch_rd[0] = {1'b0, l0};
  assign latch_rd[1] = l1;
  assign latch_rd[2] = l2;
  assign latch_rd[3] = {4'h0, l3};
  assign latch_rd[4] = {4'h0, l4};
  assign latch_rd[5] = {4'h0, l5};
  assign dir_rd[0] = {1'b1, d0};
  assign dir_rd[1] = d1;
  assign dir_rd[2] = d2;
  assign dir_rd[3] = {4'hf, d3};
  assign dir_rd[4] = {4'hf, d4};
  assign dir_rd[5] = {4'hf, d5};
  assign pu_rd[0] = {1'b0, u0};
  assign pu_rd[1] = u1;
  assign pu_rd[2] = 8'h00;
  assign pu_rd[3] = {4'h0, u3};
  assign pu_rd[4] = {4'h0, u4};
  assign pu_rd[5] = {4'h0, u5};
  assign port_rd[0] = {1'b0, r0};
  assign port_rd[1] = r1;
  assign port_rd[2] = r2;
  assign port_rd[3] = {4'h0, r3};
  assign port_rd[4] = {4'h0, r4};
  assign port_rd[5] = {4'h0, r5};

  // read mux and address decode
  always_comb begin
    rd_mux = 32'h0000_0000;
    mapped = 1'b0;
    for (int n = 0; n < NUM_PORTS; n++) begin
      if (idx == IDX_LATCH_BASE + 8'(n)) begin
        rd_mux = {24'h000000, port_rd[n]}; // [R19]
        mapped = 1'b1;
      end
      if (idx == IDX_DIR_BASE + 8'(n)) begin
        rd_mux = {24'h000000, dir_rd[n]};
        mapped = 1'b1;
      end
      if (idx == IDX_PU_BASE + 8'(n) && n != 2) begin
        rd_mux = {24'h000000, pu_rd[n]};
        mapped = 1'b1;
      end
    end
    case (idx)
      IDX_ANALOG_DIGITAL_PIN_CONFIG: begin
        rd_mux = {24'h000000, analog_digital_pin_config_q};
        mapped = 1'b1;
      end
      IDX_ADS: begin
        rd_mux = {29'h0000_0000, ads_q};
        mapped = 1'b1;
      end
      IDX_BITWR: begin
        mapped = 1'b1;
      end
      IDX_STATUS: begin
        rd_mux = {24'h000000, prohibited}; // [R12]
        mapped = !pwrite;
      end
      default: begin
      end
    endcase
    if (paddr[ADDR_W-1:IDX_MSB+1] != '0 || paddr[IDX_LSB-1:0] != '0) begin
      mapped = 1'b0;
    end
  end

  // apb answer: no wait state, pready high in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready_q <= 1'b1;
      pslverr_q <= !mapped;
      prdata_q <= pwrite ? 32'h0000_0000 : (mapped ? rd_mux : 32'h0000_0000);
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;
endmodule : gpz_ports
`default_nettype wire
